// >>> design/dlc_loop_config.sv
`default_nettype none
module dlc_loop_config import dlc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // processor register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // loop status from the rest of the device
  input wire logic auto_bandwidth_switch,
  input wire logic main_loop_locked,
  input wire logic build_out_enable,
  input wire logic [2:0] aux_bandwidth_code,
  input wire logic main_low_rate_input,
  input wire logic aux_low_rate_input,
  // settings in force
  output dlc_bw_t main_bandwidth,
  output dlc_damping_select_t main_damping,
  output dlc_damping_select_t aux_damping,
  output logic main_pd2_active,
  output logic [2:0] main_pd2_gain,
  output logic aux_pd2_active,
  output logic [2:0] aux_pd2_gain,
  // offset in units of clock period / 2^11
  output logic [15:0] phase_offset_applied,
  output logic phase_offset_ramping
);
  logic [7:0] lock_bw_q, lock_bw_d;
  logic [7:0] acq_bw_q, acq_bw_d;
  logic [7:0] aux_gd_q, aux_gd_d;
  logic [7:0] main_gd_q, main_gd_d;
  logic [7:0] aux_dg_q, aux_dg_d;
  logic [7:0] main_dg_q, main_dg_d;
  logic [15:0] ofs_q, ofs_d;
  logic [7:0] ofs_lo_pend_q, ofs_lo_pend_d;
  logic [7:0] ofs_hi_snap_q, ofs_hi_snap_d;
  logic [7:0] rdata_q, rdata_d;
  dlc_bw_t main_bw_q, main_bw_d;
  dlc_damping_select_t main_damping_select_q, aux_damping_select_q;
  dlc_damping_select_t main_damping_select_c, aux_damping_select_c;
  logic main_act_q, aux_act_q;
  logic [2:0] main_gain_q, main_gain_d;
  logic [2:0] aux_gain_q, aux_gain_d;
  logic [2:0] main_code;
  logic wr_hit;

  always_comb begin
    lock_bw_d = lock_bw_q;
    acq_bw_d = acq_bw_q;
    aux_gd_d = aux_gd_q;
    main_gd_d = main_gd_q;
    aux_dg_d = aux_dg_q;
    main_dg_d = main_dg_q;
    ofs_d = ofs_q;
    ofs_lo_pend_d = ofs_lo_pend_q;
    ofs_hi_snap_d = ofs_hi_snap_q;
    rdata_d = rdata_q;
    wr_hit = reg_wr;
    // unstored bits are masked on write and forced on read
    if (wr_hit) begin
      unique case (reg_addr)
        ADDR_LOCK_BW: lock_bw_d = reg_wdata & MASK_BW;
        ADDR_ACQ_BW: acq_bw_d = reg_wdata & MASK_BW;
        ADDR_AUX_GD: aux_gd_d = reg_wdata & MASK_GD;
        ADDR_MAIN_GD: main_gd_d = reg_wdata & MASK_GD;
        ADDR_AUX_DG: aux_dg_d = reg_wdata & MASK_DG;
        ADDR_MAIN_DG: main_dg_d = reg_wdata & MASK_DG;
        ADDR_OFS_LO: ofs_lo_pend_d = reg_wdata;
        ADDR_OFS_HI: ofs_d = {reg_wdata, ofs_lo_pend_q};
        default: ;
      endcase
    end
    // reads of unmapped offsets return zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_LOCK_BW: rdata_d = lock_bw_q | FIXED_BW;
        ADDR_ACQ_BW: rdata_d = acq_bw_q | FIXED_BW;
        ADDR_AUX_GD: rdata_d = aux_gd_q | FIXED_GD;
        ADDR_MAIN_GD: rdata_d = main_gd_q | FIXED_GD;
        ADDR_AUX_DG: rdata_d = aux_dg_q | FIXED_DG;
        ADDR_MAIN_DG: rdata_d = main_dg_q | FIXED_DG;
        ADDR_OFS_LO: begin
          rdata_d = ofs_q[7:0];
          ofs_hi_snap_d = ofs_q[15:8];
        end
        ADDR_OFS_HI: rdata_d = ofs_hi_snap_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_comb begin
    // acquisition setting only counts with the switch set
    if (auto_bandwidth_switch && !main_loop_locked) begin
      main_code = acq_bw_q[BW_HI:BW_LO];
    end else begin
      main_code = lock_bw_q[BW_HI:BW_LO];
    end
    main_bw_d = dlc_main_bw(main_code);
    main_gain_d = 3'h0;
    aux_gain_d = 3'h0;
    if (main_dg_q[EN_BIT]) begin
      main_gain_d = main_low_rate_input ? main_gd_q[LRG_HI:LRG_LO]
                                        : main_dg_q[HRG_HI:HRG_LO];
    end
    if (aux_dg_q[EN_BIT]) begin
      aux_gain_d = aux_low_rate_input ? aux_gd_q[LRG_HI:LRG_LO]
                                      : aux_dg_q[HRG_HI:HRG_LO];
    end
  end

  dlc_damping_select_decode u_main_damping_select (
    .damping_select_sel(main_gd_q[DAMPING_SELECT_HI:DAMPING_SELECT_LO]),
    .bw(main_bw_q),
    .damping(main_damping_select_c)
  );

  dlc_damping_select_decode u_aux_damping_select (
    .damping_select_sel(aux_gd_q[DAMPING_SELECT_HI:DAMPING_SELECT_LO]),
    .bw(dlc_aux_bw(aux_bandwidth_code)),
    .damping(aux_damping_select_c)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_bw_q <= RST_LOCK_BW;
      acq_bw_q <= RST_ACQ_BW;
      aux_gd_q <= RST_GD;
      main_gd_q <= RST_GD;
      aux_dg_q <= RST_DG;
      main_dg_q <= RST_DG;
      ofs_q <= {RST_OFS, RST_OFS};
      ofs_lo_pend_q <= RST_OFS;
      ofs_hi_snap_q <= RST_OFS;
      rdata_q <= 8'h00;
      main_bw_q <= BW_35;
      main_damping_select_q <= DF_5;
      aux_damping_select_q <= DF_5;
      main_act_q <= 1'b0;
      aux_act_q <= 1'b0;
      main_gain_q <= 3'h0;
      aux_gain_q <= 3'h0;
    end else begin
      lock_bw_q <= lock_bw_d;
      acq_bw_q <= acq_bw_d;
      aux_gd_q <= aux_gd_d;
      main_gd_q <= main_gd_d;
      aux_dg_q <= aux_dg_d;
      main_dg_q <= main_dg_d;
      ofs_q <= ofs_d;
      ofs_lo_pend_q <= ofs_lo_pend_d;
      ofs_hi_snap_q <= ofs_hi_snap_d;
      rdata_q <= rdata_d;
      main_bw_q <= main_bw_d;
      main_damping_select_q <= main_damping_select_c;
      aux_damping_select_q <= aux_damping_select_c;
      main_act_q <= main_dg_q[EN_BIT];
      aux_act_q <= aux_dg_q[EN_BIT];
      main_gain_q <= main_gain_d;
      aux_gain_q <= aux_gain_d;
    end
  end

  // offset unit scales with the locked clock, so no ps math here
  dlc_offset_ramp u_ramp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .target(ofs_q),
    .apply_en(main_loop_locked && !build_out_enable),
    .applied(phase_offset_applied),
    .ramping(phase_offset_ramping)
  );

  assign reg_rdata = rdata_q;
  assign main_bandwidth = main_bw_q;
  assign main_damping = main_damping_select_q;
  assign aux_damping = aux_damping_select_q;
  assign main_pd2_active = main_act_q;
  assign main_pd2_gain = main_gain_q;
  assign aux_pd2_active = aux_act_q;
  assign aux_pd2_gain = aux_gain_q;

  // checks
  logic any_wr_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      any_wr_q <= 1'b0;
    end else begin
      any_wr_q <= any_wr_q | reg_wr;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_lock_35;
    reg_wr && reg_addr == ADDR_LOCK_BW && reg_wdata[2:0] == BWC_35
      && !auto_bandwidth_switch ##1 !auto_bandwidth_switch
      |=> main_bandwidth == BW_35;
  endproperty
  a_lock_35: assert property (p_lock_35)
    else $error("35 Hz not applied");

  property p_acq_rst;
    reg_rd && reg_addr == ADDR_ACQ_BW && !reg_wr && !any_wr_q
      |=> reg_rdata == RST_ACQ_BW;
  endproperty
  a_acq_rst: assert property (p_acq_rst) else $error("acq reset value");

  property p_no_auto;
    $past(!auto_bandwidth_switch)
      |-> main_bandwidth == dlc_main_bw($past(lock_bw_q[2:0]));
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("locked bw not used");

  property p_auto_acq;
    $past(auto_bandwidth_switch && !main_loop_locked)
      |-> main_bandwidth == dlc_main_bw($past(acq_bw_q[2:0]));
  endproperty
  a_auto_acq: assert property (p_auto_acq)
    else $error("acq bw not used");

  property p_rsv_keep;
    reg_wr && reg_addr == ADDR_ACQ_BW ##1
      reg_rd && !reg_wr && reg_addr == ADDR_ACQ_BW
      |=> reg_rdata[4:3] == $past(reg_wdata[4:3], 2);
  endproperty
  a_rsv_keep: assert property (p_rsv_keep) else $error("reserved lost");

  property p_aux_20;
    aux_gd_q[2:0] == DS_HI && aux_bandwidth_code == AUX_70
      |=> aux_damping == DF_20;
  endproperty
  a_aux_20: assert property (p_aux_20) else $error("aux damping 20");

  property p_gd_rst;
    reg_rd && reg_addr == ADDR_MAIN_GD && !reg_wr && !any_wr_q
      |=> reg_rdata == RST_GD;
  endproperty
  a_gd_rst: assert property (p_gd_rst) else $error("damping reset");

  property p_low_gain;
    main_dg_q[7] && main_low_rate_input
      |=> main_pd2_gain == $past(main_gd_q[6:4]);
  endproperty
  a_low_gain: assert property (p_low_gain) else $error("low gain");

  property p_gain_off;
    !main_dg_q[7] |=> !main_pd2_active && main_pd2_gain == 3'h0;
  endproperty
  a_gain_off: assert property (p_gain_off) else $error("gain off");

  property p_pair;
    reg_wr && reg_addr == ADDR_OFS_LO ##1 reg_wr && reg_addr == ADDR_OFS_HI
      |=> ofs_q == {$past(reg_wdata), $past(reg_wdata, 2)};
  endproperty
  a_pair: assert property (p_pair) else $error("offset pair");

  property p_lo_hold;
    reg_wr && reg_addr == ADDR_OFS_LO |=> $stable(ofs_q);
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("low applied");

  property p_ramp;
    phase_offset_applied == $past(phase_offset_applied)
      || phase_offset_applied == $past(phase_offset_applied) + 16'h0001
      || phase_offset_applied == $past(phase_offset_applied) - 16'h0001;
  endproperty
  a_ramp: assert property (p_ramp) else $error("offset stepped");

  property p_unlocked;
    !main_loop_locked && phase_offset_applied == 16'h0000
      |=> phase_offset_applied == 16'h0000;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("offset used");

  c_ramp: cover property (phase_offset_ramping ##1 !phase_offset_ramping);
  c_auto: cover property (auto_bandwidth_switch && $rose(main_loop_locked));
  c_pair: cover property (reg_wr && reg_addr == ADDR_OFS_LO
                          ##1 reg_wr && reg_addr == ADDR_OFS_HI);
endmodule
`default_nettype wire

// >>> design/dlc_pkg.sv
`default_nettype none
package dlc_pkg;
  // clock and offset ramp pacing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OFS_STEP_NS = 1000;
  localparam int OFS_STEP_CYC =
    (OFS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFS_CNT_W = 8;
  localparam logic [OFS_CNT_W-1:0] OFS_STEP_LAST =
    OFS_CNT_W'(OFS_STEP_CYC - 1);

  // register offsets
  localparam logic [7:0] ADDR_LOCK_BW = 8'h67;
  localparam logic [7:0] ADDR_ACQ_BW = 8'h69;
  localparam logic [7:0] ADDR_AUX_GD = 8'h6a;
  localparam logic [7:0] ADDR_MAIN_GD = 8'h6b;
  localparam logic [7:0] ADDR_AUX_DG = 8'h6c;
  localparam logic [7:0] ADDR_MAIN_DG = 8'h6d;
  localparam logic [7:0] ADDR_OFS_LO = 8'h70;
  localparam logic [7:0] ADDR_OFS_HI = 8'h71;

  // reset values
  localparam logic [7:0] RST_LOCK_BW = 8'h00;
  localparam logic [7:0] RST_ACQ_BW = 8'h01;
  localparam logic [7:0] RST_GD = 8'h13;
  localparam logic [7:0] RST_DG = 8'hc2;
  localparam logic [7:0] RST_OFS = 8'h00;

  // bits that are not stored read back as their reset value
  localparam logic [7:0] FIXED_BW = 8'h00;
  localparam logic [7:0] FIXED_GD = 8'h00;
  localparam logic [7:0] FIXED_DG = 8'h40;
  // bits that hold state; the others are dropped on write
  localparam logic [7:0] MASK_BW = 8'h1f;
  localparam logic [7:0] MASK_GD = 8'h77;
  localparam logic [7:0] MASK_DG = 8'h87;

  // field positions
  localparam int BW_HI = 2;
  localparam int BW_LO = 0;
  localparam int RSV_HI = 4;
  localparam int RSV_LO = 3;
  localparam int DAMPING_SELECT_HI = 2;
  localparam int DAMPING_SELECT_LO = 0;
  localparam int LRG_HI = 6;
  localparam int LRG_LO = 4;
  localparam int HRG_HI = 2;
  localparam int HRG_LO = 0;
  localparam int EN_BIT = 7;

  // main loop bandwidth codes
  localparam logic [2:0] BWC_35 = 3'h0;
  localparam logic [2:0] BWC_70 = 3'h1;
  localparam logic [2:0] BWC_18B = 3'h3;
  localparam logic [2:0] BWC_120 = 3'h4;
  localparam logic [2:0] BWC_250 = 3'h5;
  localparam logic [2:0] BWC_400 = 3'h6;
  localparam logic [2:0] BWC_18A = 3'h7;
  // aux loop bandwidth codes
  localparam logic [2:0] AUX_18 = 3'h0;
  localparam logic [2:0] AUX_35 = 3'h1;
  localparam logic [2:0] AUX_70 = 3'h2;
  // damping selection codes
  localparam logic [2:0] DS_1P2 = 3'h1;
  localparam logic [2:0] DS_2P5 = 3'h2;
  localparam logic [2:0] DS_5 = 3'h3;
  localparam logic [2:0] DS_MID = 3'h4;
  localparam logic [2:0] DS_HI = 3'h5;

  typedef enum logic [3:0] {
    BW_UNDEF = 4'h0, BW_4 = 4'h1, BW_8 = 4'h2, BW_18 = 4'h3,
    BW_35 = 4'h4, BW_70 = 4'h5, BW_120 = 4'h6, BW_250 = 4'h7,
    BW_400 = 4'h8
  } dlc_bw_t;

  typedef enum logic [2:0] {
    DF_UNDEF = 3'h0, DF_1P2 = 3'h1, DF_2P5 = 3'h2, DF_5 = 3'h3,
    DF_10 = 3'h4, DF_20 = 3'h5
  } dlc_damping_select_t;

  function automatic dlc_bw_t dlc_main_bw(input logic [2:0] code);
    dlc_bw_t r;
    unique case (code)
      BWC_18A, BWC_18B: r = BW_18;
      BWC_35: r = BW_35;
      BWC_70: r = BW_70;
      BWC_120: r = BW_120;
      BWC_250: r = BW_250;
      BWC_400: r = BW_400;
      default: r = BW_UNDEF;
    endcase
    return r;
  endfunction

  function automatic dlc_bw_t dlc_aux_bw(input logic [2:0] code);
    dlc_bw_t r;
    unique case (code)
      AUX_18: r = BW_18;
      AUX_35: r = BW_35;
      AUX_70: r = BW_70;
      default: r = BW_UNDEF;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> design/dlc_damping_select_decode.sv
`default_nettype none
module dlc_damping_select_decode import dlc_pkg::*; (
  // selection and bandwidth column
  input wire logic [2:0] damping_select_sel,
  input wire dlc_bw_t bw,
  // decoded factor
  output dlc_damping_select_t damping
);
  logic slow;
  logic low;

  always_comb begin
    // 70 Hz and up fall in the widest column
    slow = (bw == BW_4) || (bw == BW_8);
    low = slow || (bw == BW_18);
    unique case (damping_select_sel)
      DS_1P2: begin
        damping = (bw == BW_4) ? DF_5 :
                  (bw == BW_8) ? DF_2P5 : DF_1P2;
      end
      DS_2P5: damping = slow ? DF_5 : DF_2P5;
      DS_5: damping = DF_5;
      DS_MID: damping = low ? DF_5 : DF_10;
      DS_HI: begin
        damping = low ? DF_5 : (bw == BW_35) ? DF_10 : DF_20;
      end
      default: damping = DF_UNDEF;
    endcase
  end
endmodule
`default_nettype wire

// >>> design/dlc_offset_ramp.sv
`default_nettype none
module dlc_offset_ramp import dlc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // requested offset
  input wire logic [15:0] target,
  input wire logic apply_en,
  // offset in force
  output logic [15:0] applied,
  output logic ramping
);
  logic [15:0] applied_q;
  logic [15:0] applied_d;
  logic [15:0] goal;
  logic [OFS_CNT_W-1:0] tick_q;
  logic [OFS_CNT_W-1:0] tick_d;

  always_comb begin
    // an ignored offset walks back to zero, never steps
    goal = apply_en ? target : 16'h0000;
    applied_d = applied_q;
    tick_d = 8'h00;
    if (applied_q != goal) begin
      if (tick_q == OFS_STEP_LAST) begin
        if ($signed(goal) > $signed(applied_q)) begin
          applied_d = applied_q + 16'h0001;
        end else begin
          applied_d = applied_q - 16'h0001;
        end
      end else begin
        tick_d = tick_q + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_q <= 16'h0000;
      tick_q <= 8'h00;
    end else begin
      applied_q <= applied_d;
      tick_q <= tick_d;
    end
  end

  assign applied = applied_q;
  assign ramping = (applied_q != goal);
endmodule
`default_nettype wire

// >>> tb/tb_dlc_loop_config.sv
`default_nettype none
module tb_dlc_loop_config import dlc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // clock, reset, register port
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  // loop status
  logic auto_bandwidth_switch = 1'b0;
  logic main_loop_locked = 1'b0;
  logic build_out_enable = 1'b0;
  logic [2:0] aux_bandwidth_code = 3'h0;
  logic main_low_rate_input = 1'b0;
  logic aux_low_rate_input = 1'b1;
  // settings in force
  dlc_bw_t main_bandwidth;
  dlc_damping_select_t main_damping;
  dlc_damping_select_t aux_damping;
  logic main_pd2_active;
  logic aux_pd2_active;
  logic [2:0] main_pd2_gain;
  logic [2:0] aux_pd2_gain;
  logic [15:0] phase_offset_applied;
  logic phase_offset_ramping;
  int fails = 0;
  int checks_done = 0;

  dlc_loop_config u_dlc_loop_config (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .auto_bandwidth_switch(auto_bandwidth_switch),
    .main_loop_locked(main_loop_locked),
    .build_out_enable(build_out_enable),
    .aux_bandwidth_code(aux_bandwidth_code),
    .main_low_rate_input(main_low_rate_input),
    .aux_low_rate_input(aux_low_rate_input),
    .main_bandwidth(main_bandwidth),
    .main_damping(main_damping),
    .aux_damping(aux_damping),
    .main_pd2_active(main_pd2_active),
    .main_pd2_gain(main_pd2_gain),
    .aux_pd2_active(aux_pd2_active),
    .aux_pd2_gain(aux_pd2_gain),
    .phase_offset_applied(phase_offset_applied),
    .phase_offset_ramping(phase_offset_ramping)
  );

  always #5 sys_clk = ~sys_clk;

  function automatic dlc_bw_t exp_bw(input logic [2:0] c);
    case (c)
      3'h7, 3'h3: return BW_18;
      3'h0: return BW_35;
      3'h1: return BW_70;
      3'h4: return BW_120;
      3'h5: return BW_250;
      3'h6: return BW_400;
      default: return BW_UNDEF;
    endcase
  endfunction

  function automatic dlc_damping_select_t exp_df(input logic [2:0] c, dlc_bw_t bw);
    case (c)
      3'h1: return DF_1P2;
      3'h2: return DF_2P5;
      3'h3: return DF_5;
      3'h4: return (bw == BW_18) ? DF_5 : DF_10;
      3'h5: return (bw == BW_18) ? DF_5 : (bw == BW_35) ? DF_10 : DF_20;
      default: return DF_UNDEF;
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // all bus tasks start and end 1 ns after a rising edge
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // main damping lags the bandwidth register by two edges
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic ramp_to(input logic [15:0] goal);
    logic [15:0] prev;
    logic [15:0] d;
    logic step_ok;
    int n;
    prev = phase_offset_applied;
    n = 0;
    while (phase_offset_applied !== goal && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
      d = phase_offset_applied - prev;
      step_ok = (d == 16'h0) || (d == 16'h1) || (d == 16'hffff);
      check("ramp step", {15'h0, step_ok}, 16'h0001);
      prev = phase_offset_applied;
    end
    check("offset", phase_offset_applied, goal);
    check("ramping", phase_offset_ramping, 1'b0);
  endtask

  task automatic t_reset;
    rd_chk(8'h67, 8'h00);
    rd_chk(8'h69, 8'h01);
    rd_chk(8'h6a, 8'h13);
    rd_chk(8'h6b, 8'h13);
    rd_chk(8'h6c, 8'hc2);
    rd_chk(8'h6d, 8'hc2);
    rd_chk(8'h70, 8'h00);
    rd_chk(8'h71, 8'h00);
    rd_chk(8'h68, 8'h00);
    check("main bw", main_bandwidth, BW_35);
    check("main damping_select", main_damping, DF_5);
    check("aux damping_select", aux_damping, DF_5);
    check("main pd2", main_pd2_active, 1'b1);
    check("main gain", main_pd2_gain, 3'h2);
    check("aux gain", aux_pd2_gain, 3'h1);
    $display("test reset done");
  endtask

  task automatic t_bandwidth;
    for (int c = 0; c < 8; c++) begin
      wr(8'h67, 8'(c));
      settle;
      check("locked bw", main_bandwidth, exp_bw(3'(c)));
    end
    auto_bandwidth_switch = 1'b1;
    wr(8'h67, 8'h06);
    for (int c = 0; c < 8; c++) begin
      wr(8'h69, 8'(c));
      settle;
      check("acq bw", main_bandwidth, exp_bw(3'(c)));
    end
    main_loop_locked = 1'b1;
    settle;
    check("locked bw auto", main_bandwidth, BW_400);
    auto_bandwidth_switch = 1'b0;
    main_loop_locked = 1'b0;
    settle;
    check("manual bw", main_bandwidth, BW_400);
    $display("test bandwidth done");
  endtask

  task automatic t_reserved;
    wr(8'h69, 8'hff);
    rd_chk(8'h69, 8'h1f);
    wr(8'h69, 8'h00);
    rd_chk(8'h69, 8'h00);
    wr(8'h67, 8'hff);
    rd_chk(8'h67, 8'h1f);
    wr(8'h6a, 8'hff);
    rd_chk(8'h6a, 8'h77);
    wr(8'h6c, 8'h3f);
    rd_chk(8'h6c, 8'h47);
    wr(8'h6d, 8'h00);
    rd_chk(8'h6d, 8'h40);
    $display("test reserved done");
  endtask

  task automatic t_damping;
    dlc_bw_t acol [3] = '{BW_18, BW_35, BW_70};
    logic [2:0] lbw [4] = '{3'h3, 3'h0, 3'h1, 3'h4};
    // 120 Hz shares the widest column
    dlc_bw_t mcol [4] = '{BW_18, BW_35, BW_70, BW_70};
    for (int b = 0; b < 3; b++) begin
      aux_bandwidth_code = 3'(b);
      for (int c = 0; c < 8; c++) begin
        wr(8'h6a, 8'(c));
        settle;
        check("aux damping_select", aux_damping, exp_df(3'(c), acol[b]));
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h67, {5'h00, lbw[i]});
      for (int c = 0; c < 8; c++) begin
        wr(8'h6b, 8'(c));
        settle;
        check("main damping_select", main_damping, exp_df(3'(c), mcol[i]));
      end
    end
    $display("test damping done");
  endtask

  task automatic t_gain;
    wr(8'h6b, 8'h53);
    wr(8'h6d, 8'h86);
    main_low_rate_input = 1'b1;
    settle;
    check("main gain lo", main_pd2_gain, 3'h5);
    check("main pd2 on", main_pd2_active, 1'b1);
    main_low_rate_input = 1'b0;
    settle;
    check("main gain hi", main_pd2_gain, 3'h6);
    wr(8'h6d, 8'h06);
    settle;
    check("main pd2 off", main_pd2_active, 1'b0);
    check("main gain off", main_pd2_gain, 3'h0);
    wr(8'h6a, 8'h33);
    wr(8'h6c, 8'h84);
    aux_low_rate_input = 1'b1;
    settle;
    check("aux gain lo", aux_pd2_gain, 3'h3);
    check("aux pd2 on", aux_pd2_active, 1'b1);
    aux_low_rate_input = 1'b0;
    settle;
    check("aux gain hi", aux_pd2_gain, 3'h4);
    wr(8'h6c, 8'h04);
    settle;
    check("aux pd2 off", aux_pd2_active, 1'b0);
    $display("test gain done");
  endtask

  task automatic t_offset;
    main_loop_locked = 1'b1;
    wr(8'h70, 8'h05);
    repeat (200) @(posedge sys_clk);
    #1;
    check("parked low", phase_offset_applied, 16'h0000);
    wr(8'h71, 8'h00);
    check("ramp start", phase_offset_ramping, 1'b1);
    ramp_to(16'h0005);
    rd_chk(8'h70, 8'h05);
    wr(8'h70, 8'hff);
    wr(8'h71, 8'hff);
    rd_chk(8'h71, 8'h00);
    ramp_to(16'hffff);
    rd_chk(8'h70, 8'hff);
    rd_chk(8'h71, 8'hff);
    build_out_enable = 1'b1;
    ramp_to(16'h0000);
    build_out_enable = 1'b0;
    ramp_to(16'hffff);
    main_loop_locked = 1'b0;
    ramp_to(16'h0000);
    $display("test offset done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    settle;
    t_reset;
    t_bandwidth;
    t_reserved;
    t_damping;
    t_gain;
    t_offset;
    test_done;
  end

  // about 2000 cycles expected; allow several times that
  initial begin
    #200000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
